/* File: logic/lsp_defines.vh */
`ifndef LSP_DEFINES_VH
`define LSP_DEFINES_VH
// clock divider half period for the system-side bus clock (clock cycles)
`define LSP_SYSTEM_SIDE_BUS_CLOCK_HALF      4'h2
// rom read: cycles address settles before select, cycles select held
`define LSP_ROM_SETUP       4'h2
`define LSP_ROM_HOLD        4'h4
// transfer kinds
`define LSP_KIND_DIO        2'h0
`define LSP_KIND_DMA        2'h1
`define LSP_KIND_PSEUDO_DMA_TRANSFER       2'h2
// data phase length in clock cycles for every transfer kind
`define LSP_DIO_LEN         4'h4
// buffer depth
`define LSP_BUF_DEPTH       2
`endif

/* File: logic/lsp_port.v */
// What this block does
// R01: moves words by direct memory access, direct i/o or pseudo dma
// R02: test input and reset both low float every output and two-way pin
// R03: connector type output shows 1 d-shell, 0 twisted pair, 0 at reset
// R04: dedicated rom pins carry low address byte, high byte on high lines
// R05: releasing reset captures rom low address pins into board config
// R06: without straps the captured board config value is undefined
// R07: rom select asserted whenever the rom is accessed
// R08: high lines carry addr 31-24, 15-8 and data 15-8, msb first
// R09: host rom accesses put upper rom address byte on high lines
// R10: low lines carry addr 23-16, 7-0 and data 7-0, msb first
// R11: rom read data taken from low lines, bit 7 on first line
// R12: processor pulses address latch strobe at each dma cycle start
// R13: device supplies the system-side bus clock
// R14: software or power-down parks the system-side bus clock high
// R15: bus release low when higher priority party needs the bus
// R16: processor yields bus after current dma cycle when release low
// R17: system port select low for a direct i/o access, else high
// R18: data buffer enable low lets buffers drive, high keeps them off
// R19: bus owned input high means the processor holds the bus
// R20: rom read drives address, then select, samples data before release
// R21: processor reset output low on own reset or control write request
`include "lsp_defines.vh"
module lsp_port (
   // clock and reset
   input  wire        clock,
   input  wire        rst,
   input  wire        incircuit_test_input,
   // control from the host side
   input  wire        connector_dshell,
   input  wire        system_side_bus_clock_park,
   input  wire        power_down,
   input  wire        priority_request,
   input  wire        misc_reset_request,
   input  wire [1:0]  xfer_kind,
   // rom read request
   input  wire        rom_req,
   input  wire [15:0] rom_addr,
   output reg         rom_done,
   output reg  [7:0]  rom_rdata,
   // word stream toward the processor port
   input  wire        in_valid,
   output reg         in_ready,
   input  wire [31:0] in_addr,
   input  wire [15:0] in_data,
   output reg         out_busy,
   // status
   output reg  [7:0]  board_config,
   output reg         connector_type_output,
   output reg         bus_owned,
   output reg         buffers_enabled,
   // rom pins
   input  wire [7:0]  rom_low_address_pins_in,
   output reg  [7:0]  rom_low_address_pins_out,
   output reg         rom_low_address_pins_oe,
   output reg         boot_rom_select_n,
   output reg         boot_rom_select_oe,
   // system lines
   input  wire [7:0]  sys_addr_data_high_byte_in,
   output reg  [7:0]  sys_addr_data_high_byte_out,
   output reg         sys_addr_data_high_byte_oe,
   input  wire [7:0]  sys_addr_data_low_byte_in,
   output reg  [7:0]  sys_addr_data_low_byte_out,
   output reg         sys_addr_data_low_byte_oe,
   input  wire        low_address_latch_strobe,
   input  wire        data_buffer_enable_n,
   input  wire        bus_owned_indicator,
   output reg         system_side_bus_clock,
   output reg         bus_release_request_n,
   output reg         system_port_select_n,
   output reg         processor_reset_output_n,
   output reg         outputs_enabled
);

   localparam ST_IDLE  = 3'h0;
   localparam ST_ADDRH = 3'h1;
   localparam ST_ADDRL = 3'h2;
   localparam ST_DATA  = 3'h3;
   localparam ST_RSET  = 3'h4;
   localparam ST_RSEL  = 3'h5;

   // bit reversal for msb-first line numbering
   function [7:0] rev8;
      input [7:0] v;
      integer i;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            rev8[i] = v[7 - i];
         end
      end
   endfunction

   reg  [7:0]  hi_s1;
   reg  [7:0]  hi_s2;
   reg  [7:0]  lo_s1;
   reg  [7:0]  lo_s2;
   reg  [7:0]  ra_s1;
   reg  [7:0]  ra_s2;
   reg  [3:0]  ctl_s1;
   reg  [3:0]  ctl_s2;
   reg         ict_s1;
   reg         ict_s2;
   reg         strap_pending;
   reg  [3:0]  div;
   reg         clk_phase;
   reg  [2:0]  state;
   reg  [3:0]  cnt;
   reg  [31:0] buf_addr [0:`LSP_BUF_DEPTH-1];
   reg  [15:0] buf_data [0:`LSP_BUF_DEPTH-1];
   reg  [1:0]  buf_count;
   reg         wr_ptr;
   reg         rd_ptr;
   reg  [31:0] cur_addr;
   reg  [15:0] cur_data;
   reg  [1:0]  cur_kind;
   wire        buf_push;
   wire        buf_pop;
   wire        float_all;

   // two-stage synchronisers for pins
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         hi_s1  <= 8'h00;
         hi_s2  <= 8'h00;
         lo_s1  <= 8'h00;
         lo_s2  <= 8'h00;
         ctl_s1 <= 4'hF;
         ctl_s2 <= 4'hF;
      end else begin
         hi_s1  <= sys_addr_data_high_byte_in;
         hi_s2  <= hi_s1;
         lo_s1  <= sys_addr_data_low_byte_in;
         lo_s2  <= lo_s1;
         ctl_s1 <= {low_address_latch_strobe, data_buffer_enable_n,
                    bus_owned_indicator, 1'b1};
         ctl_s2 <= ctl_s1;
      end
   end

   // test input and straps sampled even in reset, so the strap value is
   // settled when reset is released; rst high means device reset low
   always @(posedge clock) begin
      ict_s1          <= incircuit_test_input;
      ict_s2          <= ict_s1;
      ra_s1           <= rom_low_address_pins_in;
      ra_s2           <= ra_s1;
      outputs_enabled <= ~float_all; // R02
   end

   assign float_all = rst & ~ict_s2; // R02
   assign buf_push  = in_valid & in_ready;
   assign buf_pop   = (state == ST_IDLE) & (buf_count != 2'h0) & ~rom_req;

   // two-entry buffer; in_ready is the back-pressure to the source
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         buf_count <= 2'h0;
         wr_ptr    <= 1'b0;
         rd_ptr    <= 1'b0;
         in_ready  <= 1'b0;
      end else begin
         if (buf_push) begin
            buf_addr[wr_ptr] <= in_addr;
            buf_data[wr_ptr] <= in_data;
            wr_ptr <= ~wr_ptr;
         end
         if (buf_pop) begin
            rd_ptr <= ~rd_ptr;
         end
         buf_count <= buf_count + {1'b0, buf_push} - {1'b0, buf_pop};
         in_ready  <= (buf_count + {1'b0, buf_push} - {1'b0, buf_pop})
                      < 2'h2;
      end
   end

   // status bits and strap capture at release of reset
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         strap_pending         <= 1'b1;
         board_config          <= 8'h00;
         connector_type_output <= 1'b0; // R03
         bus_owned             <= 1'b0;
         buffers_enabled       <= 1'b0;
      end else begin
         // value without straps is whatever floats on the pins
         if (strap_pending) begin
            board_config  <= ra_s2; // R05 R06
            strap_pending <= 1'b0;
         end
         connector_type_output <= connector_dshell; // R03
         bus_owned       <= ctl_s2[1]; // R19
         buffers_enabled <= ~ctl_s2[2]; // R18
      end
   end

   // bus clock divider with park
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         div                   <= 4'h0;
         clk_phase             <= 1'b1;
         system_side_bus_clock <= 1'b1;
      end else begin
         if (div == `LSP_SYSTEM_SIDE_BUS_CLOCK_HALF - 4'h1) begin
            div       <= 4'h0;
            clk_phase <= ~clk_phase;
         end else begin
            div <= div + 4'h1;
         end
         system_side_bus_clock <= clk_phase | system_side_bus_clock_park
                                  | power_down; // R13 R14
      end
   end

   // misc outputs
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         processor_reset_output_n <= 1'b0; // R21
         bus_release_request_n    <= 1'b1;
      end else begin
         processor_reset_output_n <= ~misc_reset_request; // R21
         bus_release_request_n    <= ~priority_request; // R15
      end
   end

   // transfer and rom sequencer
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state                       <= ST_IDLE;
         cnt                         <= 4'h0;
         cur_addr                    <= 32'h0000_0000;
         cur_data                    <= 16'h0000;
         cur_kind                    <= `LSP_KIND_DIO;
         out_busy                    <= 1'b0;
         rom_done                    <= 1'b0;
         rom_rdata                   <= 8'h00;
         rom_low_address_pins_out    <= 8'h00;
         rom_low_address_pins_oe     <= 1'b0;
         boot_rom_select_n           <= 1'b1;
         boot_rom_select_oe          <= 1'b0;
         sys_addr_data_high_byte_out <= 8'h00;
         sys_addr_data_high_byte_oe  <= 1'b0;
         sys_addr_data_low_byte_out  <= 8'h00;
         sys_addr_data_low_byte_oe   <= 1'b0;
         system_port_select_n        <= 1'b1;
      end else begin
         rom_done           <= 1'b0;
         boot_rom_select_oe <= 1'b1;
         case (state)
            ST_IDLE: begin
               out_busy <= 1'b0;
               sys_addr_data_high_byte_oe <= 1'b0;
               sys_addr_data_low_byte_oe  <= 1'b0;
               rom_low_address_pins_oe    <= 1'b0;
               system_port_select_n       <= 1'b1;
               if (rom_req) begin
                  rom_low_address_pins_out    <= rom_addr[7:0]; // R04
                  rom_low_address_pins_oe     <= 1'b1;
                  sys_addr_data_high_byte_out <= rev8(rom_addr[15:8]); // R09
                  sys_addr_data_high_byte_oe  <= 1'b1;
                  cnt   <= 4'h0;
                  state <= ST_RSET; // R20
               end else if (buf_pop) begin
                  cur_addr <= buf_addr[rd_ptr];
                  cur_data <= buf_data[rd_ptr];
                  cur_kind <= xfer_kind; // R01
                  out_busy <= 1'b1;
                  state    <= ST_ADDRH;
               end
            end
            ST_RSET: begin
               cnt <= cnt + 4'h1;
               if (cnt == `LSP_ROM_SETUP - 4'h1) begin
                  boot_rom_select_n <= 1'b0; // R07
                  cnt   <= 4'h0;
                  state <= ST_RSEL;
               end
            end
            ST_RSEL: begin
               cnt <= cnt + 4'h1;
               if (cnt == `LSP_ROM_HOLD - 4'h1) begin
                  rom_rdata         <= rev8(lo_s2); // R11 R20
                  rom_done          <= 1'b1;
                  boot_rom_select_n <= 1'b1;
                  state             <= ST_IDLE;
               end
            end
            ST_ADDRH: begin
               // upper halves: 31-24 high, 23-16 low
               sys_addr_data_high_byte_out <= rev8(cur_addr[31:24]); // R08
               sys_addr_data_low_byte_out  <= rev8(cur_addr[23:16]); // R10
               sys_addr_data_high_byte_oe  <= 1'b1;
               sys_addr_data_low_byte_oe   <= 1'b1;
               if (cur_kind == `LSP_KIND_DIO) begin
                  system_port_select_n <= 1'b0; // R17
               end
               state <= ST_ADDRL;
            end
            ST_ADDRL: begin
               sys_addr_data_high_byte_out <= rev8(cur_addr[15:8]); // R08
               sys_addr_data_low_byte_out  <= rev8(cur_addr[7:0]); // R10
               cnt   <= 4'h0;
               state <= ST_DATA;
            end
            ST_DATA: begin
               sys_addr_data_high_byte_out <= rev8(cur_data[15:8]); // R08
               sys_addr_data_low_byte_out  <= rev8(cur_data[7:0]); // R10
               cnt <= cnt + 4'h1;
               if (cnt == `LSP_DIO_LEN - 4'h1) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule

/* File: dv/lsp_port_asserts.sv */
module lsp_port_asserts (
   // clock and controls
   input logic        clock,
   input logic        rst,
   input logic        connector_dshell,
   input logic        system_side_bus_clock_park,
   input logic        power_down,
   input logic        priority_request,
   input logic        misc_reset_request,
   // rom side
   input logic [15:0] rom_addr,
   input logic        rom_done,
   input logic        boot_rom_select_n,
   input logic [7:0]  rom_low_address_pins_out,
   // system side
   input logic [7:0]  sys_addr_data_high_byte_out,
   input logic        connector_type_output,
   input logic        system_side_bus_clock,
   input logic        bus_release_request_n,
   input logic        system_port_select_n,
   input logic        processor_reset_output_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rev_hi;
   always_comb for (int i = 0; i < 8; i++) rev_hi[i] = rom_addr[15 - i];
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   AST_PROC_RST:
      assert property (misc_reset_request |=> !processor_reset_output_n)
      else $error("processor reset not driven");
   AST_RELEASE:
      assert property (priority_request [*2] |-> !bus_release_request_n)
      else $error("bus release not requested");
   AST_PARK:
      assert property ((system_side_bus_clock_park || power_down) [*2] |->
         system_side_bus_clock) else $error("bus clock not parked");
   AST_SYSTEM_SIDE_BUS_CLOCK_RUN:
      assert property ((!system_side_bus_clock_park && !power_down) [*6] |->
         system_side_bus_clock != $past(system_side_bus_clock, 2))
      else $error("bus clock not running");
   AST_CONN:
      assert property ($stable(connector_dshell) [*3] |->
         connector_type_output == connector_dshell)
      else $error("connector type wrong");
   AST_ROM_SEL:
      assert property ($rose(rom_done) |-> !$past(boot_rom_select_n)
         && !$past(boot_rom_select_n, 4)) else $error("rom select short");
   AST_ROM_LOW:
      assert property (!boot_rom_select_n |->
         rom_low_address_pins_out == rom_addr[7:0])
      else $error("rom low address wrong");
   AST_ROM_HIGH:
      assert property (!boot_rom_select_n |->
         sys_addr_data_high_byte_out == rev_hi)
      else $error("rom high address wrong");
   cover property ($rose(rom_done));
   cover property (!system_port_select_n);
   cover property (system_side_bus_clock_park && system_side_bus_clock);
endmodule

/* File: dv/lsp_far_side.sv */
module lsp_far_side (
   // clock, straps and pins driven by the block
   input  logic       clock,
   input  logic [7:0] strap,
   input  logic       boot_rom_select_n,
   input  logic       rom_low_address_pins_oe,
   input  logic [7:0] rom_low_address_pins_out,
   input  logic       sys_addr_data_high_byte_oe,
   input  logic [7:0] sys_addr_data_high_byte_out,
   input  logic       sys_addr_data_low_byte_oe,
   input  logic [7:0] sys_addr_data_low_byte_out,
   // pins seen back by the block
   output logic [7:0] rom_low_address_pins_in,
   output logic [7:0] sys_addr_data_high_byte_in,
   output logic [7:0] sys_addr_data_low_byte_in,
   output logic       low_address_latch_strobe = 1'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] pat = 8'h5A;
   logic [7:0] rd, lo;
   logic       was_on = 1'h0;
   // released lines show a pattern that changes every cycle
   always @(posedge clock) pat <= ~{pat[6:0], pat[7]};
   always_comb begin
      for (int i = 0; i < 8; i++) rd[i] = sys_addr_data_high_byte_out[7 - i];
      rd = rd ^ rom_low_address_pins_out ^ 8'hA5;
      for (int i = 0; i < 8; i++) lo[i] = rd[7 - i];
   end
   assign sys_addr_data_low_byte_in = sys_addr_data_low_byte_oe ?
      sys_addr_data_low_byte_out : !boot_rom_select_n ? lo : pat;
   assign sys_addr_data_high_byte_in = sys_addr_data_high_byte_oe ?
      sys_addr_data_high_byte_out : pat;
   // straps act as pull resistors on the rom low address pins
   assign rom_low_address_pins_in = rom_low_address_pins_oe ?
      rom_low_address_pins_out : strap;
   always @(posedge clock) begin
      was_on <= sys_addr_data_high_byte_oe;
      low_address_latch_strobe <= sys_addr_data_high_byte_oe && !was_on;
   end
endmodule

/* File: dv/lsp_port_bench.sv */
module lsp_port_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'h0, rst = 1'h1, incircuit_test_input = 1'h1;
   logic connector_dshell, system_side_bus_clock_park, power_down, priority_request;
   logic misc_reset_request, data_buffer_enable_n, bus_owned_indicator;
   logic rom_req = 1'h0, in_valid = 1'h0;
   logic [1:0] xfer_kind = 2'h0;
   logic [15:0] rom_addr = 16'h0000, in_data = 16'h0000;
   logic [31:0] in_addr = 32'h0000_0000, r, wa [3];
   logic [15:0] wd [3];
   logic [7:0] strap, rom_rdata, board_config, rom_low_address_pins_in;
   logic [7:0] rom_low_address_pins_out, sys_addr_data_high_byte_in;
   logic [7:0] sys_addr_data_high_byte_out, sys_addr_data_low_byte_in;
   logic [7:0] sys_addr_data_low_byte_out;
   logic rom_done, in_ready, out_busy, connector_type_output, bus_owned;
   logic buffers_enabled, boot_rom_select_n, boot_rom_select_oe;
   logic rom_low_address_pins_oe, sys_addr_data_high_byte_oe;
   logic sys_addr_data_low_byte_oe, low_address_latch_strobe;
   logic system_side_bus_clock, bus_release_request_n, system_port_select_n;
   logic processor_reset_output_n, outputs_enabled;
   int unsigned seed = 36694;
   int mismatches = 0, n_checks = 0;
   wire drv = rom_low_address_pins_oe | boot_rom_select_oe | outputs_enabled
      | sys_addr_data_high_byte_oe | sys_addr_data_low_byte_oe;
   lsp_port i_dut (.*);
   lsp_far_side u_far (.*);
   initial forever #10 clock = ~clock;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] rev8(input logic [7:0] v);
      for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
   endfunction
   task step;
      @(posedge clock);
      #2;
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk8(input logic [7:0] g, e, input string m);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task chk1(input logic g, e, input string m);
      chk8({7'h00, g}, {7'h00, e}, m);
   endtask
   task tmo(input int i);
      if (i >= 60) begin
         chk1(1'h0, 1'h1, "wait ran out");
         summarize();
      end
   endtask
   task automatic do_reset(input logic t);
      rst = 1'h1;
      incircuit_test_input = t;
      r = rnd();
      strap = r[7:0];
      repeat (4) step;
      chk1(drv, t, "pin drive in reset");
      chk1(connector_type_output, 1'h0, "connector at reset");
      chk1(processor_reset_output_n, 1'h0, "processor reset");
      rst = 1'h0;
      incircuit_test_input = 1'h1;
      repeat (2) step;
      chk8(board_config, strap, "board config");
      $display("reset with test input %0d done", t);
   endtask
   task automatic push(input logic [31:0] a, input logic [15:0] d);
      int i;
      in_addr = a;
      in_data = d;
      in_valid = 1'h1;
      for (i = 0; i < 60 && !in_ready; i++) step;
      tmo(i);
      step;
   endtask
   task automatic pair(input logic [15:0] e);
      chk8(rev8(sys_addr_data_high_byte_out), e[15:8], "high lines");
      chk8(rev8(sys_addr_data_low_byte_out), e[7:0], "low lines");
      step;
   endtask
   task automatic watch(input logic [31:0] a, input logic [15:0] d);
      int i;
      for (i = 0; i < 60 && sys_addr_data_high_byte_oe; i++) step;
      tmo(i);
      for (i = 0; i < 60 && !sys_addr_data_high_byte_oe; i++) step;
      tmo(i);
      chk1(system_port_select_n, xfer_kind != 2'h0, "port select");
      chk1(out_busy, 1'h1, "busy");
      pair(a[31:16]);
      pair(a[15:0]);
      pair(d);
   endtask
   task automatic rom(input logic [15:0] a);
      int i;
      rom_addr = a;
      rom_req = 1'h1;
      for (i = 0; i < 60 && !rom_done; i++) step;
      tmo(i);
      rom_req = 1'h0;
      chk8(rom_rdata, a[7:0] ^ a[15:8] ^ 8'hA5, "rom data");
      step;
   endtask
   initial begin
      {system_side_bus_clock_park, power_down, priority_request, misc_reset_request} = 4'h0;
      {data_buffer_enable_n, bus_owned_indicator, connector_dshell} = 3'h4;
      do_reset(1'h1);
      repeat (12) begin
         r = rnd();
         {system_side_bus_clock_park, power_down, priority_request,
          misc_reset_request} = r[3:0];
         {data_buffer_enable_n, bus_owned_indicator,
          connector_dshell} = r[6:4];
         repeat (8) step;
         chk1(system_side_bus_clock | !(system_side_bus_clock_park | power_down), 1'h1,
              "park");
         chk1(bus_release_request_n, !priority_request, "release");
         chk1(processor_reset_output_n, !misc_reset_request, "reset");
         chk1(buffers_enabled, !data_buffer_enable_n, "buffers");
         chk1(bus_owned, bus_owned_indicator, "owned");
         chk1(connector_type_output, connector_dshell, "connector");
      end
      // release stays high through the transfers, so the bus is kept
      {system_side_bus_clock_park, power_down, priority_request,
       misc_reset_request} = 4'h0;
      $display("control levels done");
      for (int k = 0; k < 3; k++) begin
         xfer_kind = k[1:0];
         for (int j = 0; j < 3; j++) begin
            wa[j] = rnd();
            r = rnd();
            wd[j] = r[15:0];
         end
         if (k == 0) wa[0] = 32'h8000_0001;
         fork
            begin
               for (int j = 0; j < 3; j++) push(wa[j], wd[j]);
               in_valid = 1'h0;
            end
            for (int j = 0; j < 3; j++) watch(wa[j], wd[j]);
         join
         $display("stream kind %0d done", k);
      end
      rom(16'h0000);
      rom(16'hFFFF);
      repeat (4) begin
         r = rnd();
         rom(r[15:0]);
      end
      $display("rom reads done");
      do_reset(1'h0);
      rom(16'h8001);
      summarize();
   end
endmodule
bind lsp_port lsp_port_asserts u_chk (.*);
